// ### logic/dtc_regs.v
// What this block does
// [RL1] Rotation action zero: a rotation neither resets link clocks nor touches the datapath.
// [RL2] Action 1: rotation drops the links and resets the serial-link clocks.
// [RL3] Software should enable the link clock reset action for proper realignment.
// [RL4] Action 2: datapath ramps off and back on around the rotation.
// [RL5] Software picks the soft off/on action only with amplifier protection in use.
// [RL6] Action 3: rotation does both link clock reset and soft off/on.
// [RL7] Converter-1 mute enable set: output zeroed while its enable pin is low.
// [RL8] Converter-0 mute enable set: output zeroed while its enable pin is low.
// [RL9] Software should program the calibration clock divider to 0xA.
// [RL10] Calibration enable low holds the engine in reset; high enables it.
// [RL11] Software should set calibration mode field to 1.
// [RL12] Mode, start and status are banked per converter, steered by page bits.
// [RL13] Writing the start bit launches calibration on the paged converter.
// [RL14] Software writes nothing in the calibration range while calibration is active.
// [RL15] Active flag reads one while the routine runs.
// [RL16] Failure flag reads one when the routine failed.
// [RL17] Complete flag reads one once the routine has finished.
// [RL18] Start sets active, clears done and fail; end sets done and maybe fail.
`include "dtc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module dtc_regs #(
  parameter NUM_CONV     = 2,
  parameter RAMP_CYC     = `DTC_RAMP_CYC,
  parameter LINK_RST_CYC = `DTC_LINK_RST_CYC,
  parameter CAL_STEP_CYC = `DTC_CAL_STEP_CYC
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Transmit enable pins, asynchronous
  input  wire        transmit_enable_pin_0,
  input  wire        transmit_enable_pin_1,
  // Synchronization rotation event and calibration result
  input  wire        sync_rotation_pulse,
  input  wire [1:0]  cal_search_fail,
  // Datapath and link controls
  output reg  [1:0]  datapath_mute,
  output reg         link_clock_reset,
  output reg         datapath_soft_off,
  output reg         rotation_busy,
  output reg  [3:0]  cal_clock_divider,
  output reg  [3:0]  cal_mode_out,
  // Interrupt
  output reg         irq
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_OFF  = 4'b0010;
  localparam [3:0] S_LINK = 4'b0100;
  localparam [3:0] S_ON   = 4'b1000;
  localparam [15:0] RAMP_C = RAMP_CYC;
  localparam [15:0] LINK_C = LINK_RST_CYC;

  // Index decode shared by read and write paths
  function is_idx;
    input [13:0] addr;
    input [11:0] idx;
    begin
      is_idx = (addr[13:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  reg  [1:0]  page_q;
  reg  [1:0]  rot_mode_q;
  reg  [1:0]  mute_en_q;
  reg  [7:0]  cal_div_q;
  reg         cal_en_q;
  reg  [3:0]  cal_mode_q;
  reg  [1:0]  cal_start_q;
  reg  [4:0]  irq_stat_q;
  reg  [4:0]  irq_mask_q;
  reg  [3:0]  state_q;
  reg  [15:0] tmr_q;
  reg  [1:0]  rot_act_q;
  reg  [2:0]  sync0_q;
  reg  [2:0]  sync1_q;
  reg  [1:0]  txen_q;
  reg         rot_done_q;
  wire [1:0]  eng_active;
  wire [1:0]  eng_fail;
  wire [1:0]  eng_done;
  wire [1:0]  eng_done_pls;
  wire [1:0]  eng_fail_pls;
  wire        setup;
  wire        access;
  wire        wr;
  wire        mapped;
  wire        rd_page;
  reg  [31:0] rdata_d;
  wire [4:0]  irq_set_d;
  wire [1:0]  txen_f;

  assign setup  = psel & ~penable & ~pready;
  assign access = psel & penable & pready;
  assign wr     = access & pwrite & ~pslverr;
  assign mapped = is_idx(paddr, `DTC_IDX_PAGE) | is_idx(paddr, `DTC_IDX_ROTATION) |
                  is_idx(paddr, `DTC_IDX_TX_MUTE) | is_idx(paddr, `DTC_IDX_CAL_DIV) |
                  is_idx(paddr, `DTC_IDX_CAL_CTRL) | is_idx(paddr, `DTC_IDX_CAL_STAT) |
                  is_idx(paddr, `DTC_IDX_IRQ_STATUS) | is_idx(paddr, `DTC_IDX_IRQ_MASK);
  // Reads of paged fields show the lowest selected converter
  assign rd_page = ~page_q[0] & page_q[1];

  // Read mux; reserved bits read zero
  always @* begin
    rdata_d = 32'h00000000;
    if (is_idx(paddr, `DTC_IDX_PAGE))
      rdata_d[1:0] = page_q;
    if (is_idx(paddr, `DTC_IDX_ROTATION))
      rdata_d[1:0] = rot_mode_q;
    if (is_idx(paddr, `DTC_IDX_TX_MUTE)) begin
      rdata_d[`DTC_MUTE0_BIT] = mute_en_q[0];
      rdata_d[`DTC_MUTE1_BIT] = mute_en_q[1];
    end
    if (is_idx(paddr, `DTC_IDX_CAL_DIV))
      rdata_d[7:0] = cal_div_q;
    if (is_idx(paddr, `DTC_IDX_CAL_CTRL)) begin
      rdata_d[`DTC_CAL_EN_BIT] = cal_en_q;
      rdata_d[2:1] = rd_page ? cal_mode_q[3:2] : cal_mode_q[1:0]; // [RL12]
    end
    if (is_idx(paddr, `DTC_IDX_CAL_STAT)) begin
      rdata_d[`DTC_CAL_ACTIVE_BIT] = eng_active[rd_page]; // [RL12] [RL15]
      rdata_d[`DTC_CAL_FAIL_BIT]   = eng_fail[rd_page]; // [RL16]
      rdata_d[`DTC_CAL_DONE_BIT]   = eng_done[rd_page]; // [RL17]
    end
    if (is_idx(paddr, `DTC_IDX_IRQ_STATUS))
      rdata_d[4:0] = irq_stat_q;
    if (is_idx(paddr, `DTC_IDX_IRQ_MASK))
      rdata_d[4:0] = irq_mask_q;
  end

  // APB answer: one registered wait-free access cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= (pwrite | ~mapped) ? 32'h00000000 : rdata_d;
    end
  end

  // Software-written control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q      <= `DTC_RST_PAGE;
      rot_mode_q  <= `DTC_RST_ROTATION;
      mute_en_q   <= 2'h0;
      cal_div_q   <= `DTC_RST_CAL_DIV;
      cal_en_q    <= `DTC_RST_CAL_EN;
      cal_mode_q  <= {`DTC_RST_CAL_MODE, `DTC_RST_CAL_MODE};
      cal_start_q <= 2'h0;
      irq_mask_q  <= `DTC_RST_IRQ_MASK;
      cal_clock_divider <= `DTC_RST_CAL_CLK;
      cal_mode_out      <= {`DTC_RST_CAL_MODE, `DTC_RST_CAL_MODE};
    end else begin
      cal_start_q <= 2'h0;
      // Analog-facing copies trail the registers by one cycle
      cal_clock_divider <= cal_div_q[3:0];
      cal_mode_out      <= cal_mode_q;
      if (wr && is_idx(paddr, `DTC_IDX_PAGE))
        page_q <= pwdata[1:0];
      if (wr && is_idx(paddr, `DTC_IDX_ROTATION))
        rot_mode_q <= pwdata[1:0];
      if (wr && is_idx(paddr, `DTC_IDX_TX_MUTE)) begin
        mute_en_q[0] <= pwdata[`DTC_MUTE0_BIT];
        mute_en_q[1] <= pwdata[`DTC_MUTE1_BIT];
      end
      if (wr && is_idx(paddr, `DTC_IDX_CAL_DIV))
        cal_div_q <= pwdata[7:0];
      if (wr && is_idx(paddr, `DTC_IDX_CAL_CTRL)) begin
        cal_en_q <= pwdata[`DTC_CAL_EN_BIT]; // [RL10]
        // A write reaches every converter whose page bit is set
        if (page_q[0])
          cal_mode_q[1:0] <= pwdata[2:1]; // [RL12]
        if (page_q[1])
          cal_mode_q[3:2] <= pwdata[2:1]; // [RL12]
        cal_start_q <= page_q & {2{pwdata[`DTC_CAL_START_BIT]}}; // [RL13]
      end
      if (wr && is_idx(paddr, `DTC_IDX_IRQ_MASK))
        irq_mask_q <= pwdata[4:0];
    end
  end

  // Per-converter calibration engines
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g = g + 1) begin : g_cal
      dtc_cal_engine #(
        .STEP_CYC     (CAL_STEP_CYC)
      ) u_eng (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (cal_en_q),
        .start        (cal_start_q[g]),
        .divider      (cal_div_q[3:0]),
        .fail_in      (cal_search_fail[g]),
        .active_q     (eng_active[g]),
        .fail_q       (eng_fail[g]),
        .done_q       (eng_done[g]),
        .done_pulse_q (eng_done_pls[g]),
        .fail_pulse_q (eng_fail_pls[g])
      );
    end
  endgenerate

  // Pin synchronisers: a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync0_q <= 3'h7;
      sync1_q <= 3'h7;
      txen_q  <= 2'h3;
      datapath_mute <= 2'h0;
    end else begin
      sync0_q <= {sync0_q[1:0], transmit_enable_pin_0};
      sync1_q <= {sync1_q[1:0], transmit_enable_pin_1};
      txen_q  <= txen_f;
      // Mute follows the filtered level one cycle later, registered like txen_q
      datapath_mute[0] <= mute_en_q[0] & ~txen_f[0]; // [RL8]
      datapath_mute[1] <= mute_en_q[1] & ~txen_f[1]; // [RL7]
    end
  end

  // Filtered level: stage three once stage two agrees, else the last accepted level
  assign txen_f[0] = (sync0_q[1] == sync0_q[2]) ? sync0_q[2] : txen_q[0];
  assign txen_f[1] = (sync1_q[1] == sync1_q[2]) ? sync1_q[2] : txen_q[1];

  // Rotation sequencer; action latched at the event so a mid-sequence write cannot tear it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= S_IDLE;
      tmr_q             <= 16'h0000;
      rot_act_q         <= 2'h0;
      link_clock_reset  <= 1'b0;
      datapath_soft_off <= 1'b0;
      rotation_busy     <= 1'b0;
      rot_done_q        <= 1'b0;
    end else begin
      rot_done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (sync_rotation_pulse) begin
            rot_act_q <= rot_mode_q;
            if (rot_mode_q[`DTC_ROT_SOFT_BIT]) begin // [RL4] [RL6]
              state_q           <= S_OFF;
              tmr_q             <= RAMP_C - 16'h0001;
              datapath_soft_off <= 1'b1;
              rotation_busy     <= 1'b1;
            end else if (rot_mode_q[`DTC_ROT_LINK_BIT]) begin // [RL2]
              state_q          <= S_LINK;
              tmr_q            <= LINK_C - 16'h0001;
              link_clock_reset <= 1'b1;
              rotation_busy    <= 1'b1;
            end else begin
              rot_done_q <= 1'b1; // [RL1]
            end
          end
        end
        S_OFF: begin
          if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
          end else if (rot_act_q[`DTC_ROT_LINK_BIT]) begin // [RL6]
            state_q          <= S_LINK;
            tmr_q            <= LINK_C - 16'h0001;
            link_clock_reset <= 1'b1;
          end else begin
            state_q           <= S_ON;
            tmr_q             <= RAMP_C - 16'h0001;
            datapath_soft_off <= 1'b0;
          end
        end
        S_LINK: begin
          if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
          end else begin
            link_clock_reset <= 1'b0;
            if (rot_act_q[`DTC_ROT_SOFT_BIT]) begin
              state_q           <= S_ON;
              tmr_q             <= RAMP_C - 16'h0001;
              datapath_soft_off <= 1'b0;
            end else begin
              state_q       <= S_IDLE;
              rotation_busy <= 1'b0;
              rot_done_q    <= 1'b1;
            end
          end
        end
        S_ON: begin
          if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
          end else begin
            state_q       <= S_IDLE;
            rotation_busy <= 1'b0;
            rot_done_q    <= 1'b1;
          end
        end
        default: begin
          state_q           <= S_IDLE;
          link_clock_reset  <= 1'b0;
          datapath_soft_off <= 1'b0;
          rotation_busy     <= 1'b0;
        end
      endcase
    end
  end

  // Event bits in status layout: done0, done1, fail0, fail1, rotation
  assign irq_set_d = {rot_done_q, eng_fail_pls, eng_done_pls};

  // Sticky events; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 5'h00;
      irq        <= 1'b0;
    end else begin
      if (wr && is_idx(paddr, `DTC_IDX_IRQ_STATUS))
        irq_stat_q <= (irq_stat_q & ~pwdata[4:0]) | irq_set_d;
      else
        irq_stat_q <= irq_stat_q | irq_set_d;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule // dtc_regs
`default_nettype wire

// ### logic/dtc_consts.vh
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
// Register indices; byte address is four times the index
`define DTC_IDX_PAGE        12'h008
`define DTC_IDX_ROTATION    12'h03b
`define DTC_IDX_TX_MUTE     12'h03f
`define DTC_IDX_CAL_DIV     12'h050
`define DTC_IDX_CAL_CTRL    12'h051
`define DTC_IDX_CAL_STAT    12'h052
`define DTC_IDX_IRQ_STATUS  12'h0f0
`define DTC_IDX_IRQ_MASK    12'h0f1
// Field positions
`define DTC_ROT_LINK_BIT    0
`define DTC_ROT_SOFT_BIT    1
`define DTC_MUTE0_BIT       4
`define DTC_MUTE1_BIT       5
`define DTC_CAL_EN_BIT      7
`define DTC_CAL_START_BIT   0
`define DTC_CAL_ACTIVE_BIT  2
`define DTC_CAL_FAIL_BIT    1
`define DTC_CAL_DONE_BIT    0
// Interrupt status layout
`define DTC_IRQ_DONE0_BIT   0
`define DTC_IRQ_DONE1_BIT   1
`define DTC_IRQ_FAIL0_BIT   2
`define DTC_IRQ_FAIL1_BIT   3
`define DTC_IRQ_ROT_BIT     4
`define DTC_IRQ_W           5
// Reset values
`define DTC_RST_PAGE        2'h1
`define DTC_RST_ROTATION    2'h0
`define DTC_RST_CAL_DIV     8'h28
`define DTC_RST_CAL_CLK     4'h8
`define DTC_RST_CAL_EN      1'h1
`define DTC_RST_CAL_MODE    2'h1
`define DTC_RST_IRQ_MASK    5'h00
// Timing
`define DTC_CLK_NS          25
`define DTC_RAMP_NS         1000
`define DTC_RAMP_CYC        ((`DTC_RAMP_NS + `DTC_CLK_NS - 1) / `DTC_CLK_NS)
`define DTC_LINK_RST_NS     200
`define DTC_LINK_RST_CYC    ((`DTC_LINK_RST_NS + `DTC_CLK_NS - 1) / `DTC_CLK_NS)
`define DTC_CAL_STEP_CYC    64
`endif

// ### logic/dtc_cal_engine.v
`timescale 1ns/1ps
`default_nettype none
module dtc_cal_engine #(
  parameter STEP_CYC = 64
) (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       enable,
  input  wire       start,
  input  wire [3:0] divider,
  input  wire       fail_in,
  // Status
  output reg        active_q,
  output reg        fail_q,
  output reg        done_q,
  output reg        done_pulse_q,
  output reg        fail_pulse_q
);
  localparam [15:0] STEP = STEP_CYC;
  reg [19:0] cnt_q;

  // Routine length scales with the divider; engine held in reset while disabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q     <= 1'b0;
      fail_q       <= 1'b0;
      done_q       <= 1'b0;
      done_pulse_q <= 1'b0;
      fail_pulse_q <= 1'b0;
      cnt_q        <= 20'h00000;
    end else begin
      done_pulse_q <= 1'b0;
      fail_pulse_q <= 1'b0;
      if (!enable) begin // [RL10]
        active_q <= 1'b0;
        fail_q   <= 1'b0;
        done_q   <= 1'b0;
        cnt_q    <= 20'h00000;
      end else if (start) begin // [RL13] [RL18]
        active_q <= 1'b1;
        fail_q   <= 1'b0;
        done_q   <= 1'b0;
        cnt_q    <= {4'h0, STEP} * ({16'h0000, divider} + 20'h00001) - 20'h00001; // Widened so divider 15 cannot wrap
      end else if (active_q) begin
        if (cnt_q == 20'h00000) begin
          active_q     <= 1'b0; // [RL15]
          done_q       <= 1'b1; // [RL17] [RL18]
          fail_q       <= fail_in; // [RL16]
          done_pulse_q <= 1'b1;
          fail_pulse_q <= fail_in;
        end else begin
          cnt_q <= cnt_q - 20'h00001;
        end
      end
    end
  end
endmodule // dtc_cal_engine
`default_nettype wire

// ### sim/dtc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_regs_props #(
  parameter RAMP_CYC     = 40,
  parameter LINK_RST_CYC = 8
) (
  // Clock, reset and bus handshake
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Pins and datapath controls
  input wire logic       transmit_enable_pin_0,
  input wire logic       transmit_enable_pin_1,
  input wire logic [1:0] datapath_mute,
  input wire logic       link_clock_reset,
  input wire logic       datapath_soft_off,
  input wire logic       rotation_busy,
  input wire logic [3:0] cal_clock_divider,
  input wire logic [3:0] cal_mode_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] lk_n_q;
  logic [7:0] sf_n_q;

  // Run lengths, read at the falling edge; counters avoid long repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_n_q <= 8'h00;
      sf_n_q <= 8'h00;
    end else begin
      lk_n_q <= link_clock_reset ? lk_n_q + 8'h01 : 8'h00;
      sf_n_q <= datapath_soft_off ? sf_n_q + 8'h01 : 8'h00;
    end
  end

  // Setup phase of a bus transfer
  sequence seq_setup;
    psel && !penable && !pready;
  endsequence

  chk_ready_next: assert property (seq_setup |=> pready) else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_mute_conv0: assert property (datapath_mute[0] |-> !$past(transmit_enable_pin_0, 4))
    else $error("conv0 muted with pin high");
  chk_mute_conv1: assert property (datapath_mute[1] |-> !$past(transmit_enable_pin_1, 4))
    else $error("conv1 muted with pin high");
  chk_link_width: assert property ($fell(link_clock_reset) |-> lk_n_q == LINK_RST_CYC)
    else $error("link reset length wrong");
  chk_soft_width: assert property ($fell(datapath_soft_off) |->
    (sf_n_q == RAMP_CYC || sf_n_q == RAMP_CYC + LINK_RST_CYC)) else $error("soft off length wrong");
  chk_link_in_rot: assert property (link_clock_reset |-> rotation_busy)
    else $error("link reset outside rotation");
  chk_soft_in_rot: assert property (datapath_soft_off |-> rotation_busy)
    else $error("soft off outside rotation");
  chk_reset_vals: assert property ($rose(presetn) |-> cal_clock_divider == 4'h8 && cal_mode_out == 4'h5)
    else $error("bad values after reset");
endmodule // dtc_regs_props

bind dtc_regs dtc_regs_props #(.RAMP_CYC(RAMP_CYC), .LINK_RST_CYC(LINK_RST_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .transmit_enable_pin_0(transmit_enable_pin_0), .transmit_enable_pin_1(transmit_enable_pin_1),
  .datapath_mute(datapath_mute), .link_clock_reset(link_clock_reset), .datapath_soft_off(datapath_soft_off),
  .rotation_busy(rotation_busy), .cal_clock_divider(cal_clock_divider), .cal_mode_out(cal_mode_out)
);
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.vh"
module testbench;
  localparam int RC = 4;
  localparam int LC = 3;
  localparam int SC = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        tx0, tx1, rot_p, irq, lk, sf, busy;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  cfail, mute, fl;
  logic [3:0]  cdiv, cmode;
  logic [7:0]  rnd;
  int          bad_count, checks_done, cyc, n, nl, ns, nb;

  dtc_regs #(.RAMP_CYC(RC), .LINK_RST_CYC(LC), .CAL_STEP_CYC(SC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_enable_pin_0(tx0), .transmit_enable_pin_1(tx1), .sync_rotation_pulse(rot_p),
    .cal_search_fail(cfail), .datapath_mute(mute), .link_clock_reset(lk), .datapath_soft_off(sf),
    .rotation_busy(busy), .cal_clock_divider(cdiv), .cal_mode_out(cmode), .irq(irq)
  );

  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected mute, link reset cycles and soft off cycles
  function automatic logic [31:0] em(input logic [1:0] e, input logic [1:0] p);
    return {30'h0, e & ~p};
  endfunction
  function automatic int el(input int a);
    return a[0] ? LC : 0;
  endfunction
  function automatic int es(input int a);
    return a[1] ? (a[0] ? RC + LC : RC) : 0;
  endfunction
  // Busy spans ramp off, ramp on and any link reset
  function automatic int eb(input int a);
    return (a[1] ? 2 * RC : 0) + (a[0] ? LC : 0);
  endfunction

  task automatic c32(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One transfer; request held until ready is sampled at a rising edge, then released
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Design flops update after this read, so these are the values sampled at the edge
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rr(input logic [11:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    c32(rd, e);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, rot_p, presetn} = 5'h00;
    {tx0, tx1} = 2'h3;
    paddr = 14'h0000;
    pwdata = 32'h0;
    cfail = 2'h0;
    rnd = 8'h4e;
    {bad_count, checks_done, cyc} = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    c32(cdiv, 32'h8);
    c32(cmode, 32'h5);
    rr(`DTC_IDX_PAGE, 32'h1);
    rr(`DTC_IDX_ROTATION, 32'h0);
    rr(`DTC_IDX_TX_MUTE, 32'h0);
    rr(`DTC_IDX_CAL_DIV, 32'h28);
    rr(`DTC_IDX_CAL_CTRL, 32'h82);
    rr(`DTC_IDX_CAL_STAT, 32'h0);
    rr(`DTC_IDX_IRQ_MASK, 32'h0);
    apb(1'b0, 12'h0ff, 32'h0);
    c32(err, 32'h1);
    c32(rd, 32'h0);
    $display("test reset done");
    // Mute enables against pins, first case both enabled with both pins low
    for (int k = 0; k < 8; k++) begin
      rnd = nx(rnd);
      if (k == 0) rnd[3:0] = 4'h3;
      apb(1'b1, `DTC_IDX_TX_MUTE, {26'h0, rnd[1:0], 4'h0});
      tx0 <= rnd[2];
      tx1 <= rnd[3];
      repeat (6) @(negedge pclk);
      c32(mute, em(rnd[1:0], rnd[3:2]));
      rr(`DTC_IDX_TX_MUTE, {26'h0, rnd[1:0], 4'h0});
    end
    tx0 <= 1'b1;
    tx1 <= 1'b1;
    $display("test mute done");
    // Every rotation action, rotation interrupt unmasked
    apb(1'b1, `DTC_IDX_IRQ_MASK, 32'h10);
    for (int a = 0; a < 4; a++) begin
      apb(1'b1, `DTC_IDX_ROTATION, a);
      rot_p <= 1'b1;
      @(posedge pclk);
      rot_p <= 1'b0;
      {nl, ns, nb} = 0;
      repeat (40) begin
        @(negedge pclk);
        nl += lk;
        ns += sf;
        nb += busy;
      end
      c32(nl, el(a));
      c32(ns, es(a));
      c32(nb, eb(a));
      c32(irq, 32'h1);
      rr(`DTC_IDX_IRQ_STATUS, 32'h10);
      apb(1'b1, `DTC_IDX_IRQ_STATUS, 32'h10);
      repeat (2) @(negedge pclk);
      c32(irq, 32'h0);
    end
    $display("test rotation done");
    // Calibration per page; only done0 unmasked so conv1 shows masking
    rnd = nx(rnd);
    apb(1'b1, `DTC_IDX_CAL_DIV, {24'h0, rnd | 8'h04});
    repeat (2) @(negedge pclk);
    c32(cdiv, rnd[3:0] | 4'h4);
    rr(`DTC_IDX_CAL_DIV, {24'h0, rnd | 8'h04});
    apb(1'b1, `DTC_IDX_IRQ_MASK, 32'h01);
    for (int c = 0; c < 2; c++) begin
      rnd = nx(rnd);
      fl[c] = rnd[0];
      cfail[c] <= rnd[0];
      if (c == 1) apb(1'b1, `DTC_IDX_CAL_DIV, 32'h2a);
      apb(1'b1, `DTC_IDX_PAGE, c + 1);
      apb(1'b1, `DTC_IDX_CAL_CTRL, 32'h83);
      repeat (2) @(posedge pclk);
      rr(`DTC_IDX_CAL_STAT, 32'h4);
      n = 0;
      // Only reads while active: the calibration range must not be written
      do begin
        apb(1'b0, `DTC_IDX_CAL_STAT, 32'h0);
        n++;
      end while (rd[2] !== 1'b0 && n < 40);
      c32(rd, {30'h0, fl[c], 1'b1});
      // Interrupt trails the done flag by two edges
      @(negedge pclk);
      c32(irq, c == 0);
      rr(`DTC_IDX_IRQ_STATUS, (32'h1 << c) | ({31'h0, fl[c]} << (c + 2)));
      apb(1'b1, `DTC_IDX_IRQ_STATUS, 32'h1f);
    end
    apb(1'b1, `DTC_IDX_PAGE, 32'h1);
    rr(`DTC_IDX_CAL_STAT, {30'h0, fl[0], 1'b1});
    apb(1'b1, `DTC_IDX_PAGE, 32'h2);
    rr(`DTC_IDX_CAL_STAT, {30'h0, fl[1], 1'b1});
    apb(1'b1, `DTC_IDX_CAL_CTRL, 32'h84);
    repeat (2) @(negedge pclk);
    c32(cmode, 32'h9);
    apb(1'b1, `DTC_IDX_CAL_CTRL, 32'h04);
    rr(`DTC_IDX_CAL_STAT, 32'h0);
    $display("test calibration done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
